// ==== rtl/lsd_top.sv ====
// Operation
// - lifetime command returns seconds of operation
// - save lifetime count to flash hourly
// - enable falling edge saves if supply good
// - lifetime counter 32 bits, wraps to zero
// - reload lifetime count from flash after reset
// - zero, ones, zero within 8ms clears count
// - peak power holds largest power seen
// - writing zero clears peak power
// - running averages of power, current, temperature
// - zero write restarts average, nonzero ignored
// - peak and averages are two-byte values
// - enable low or channel off forces zero
// - high byte when all good, else low
// - divisor 8..200 divides 4MHz oscillator (code accepts any nonzero byte, range not checked)
// - zero byte puts output in high impedance
// - equal bytes give power-good independent rate
`timescale 1ns/10ps
module lsd_top #(
    parameter int unsigned SEC_TICKS = lsd_pkg::SEC_TICKS_DFLT,
    parameter int unsigned HOUR_SECS = lsd_pkg::HOUR_SECS_DFLT,
    parameter int unsigned CLR_WINDOW = lsd_pkg::CLR_WINDOW_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic lnk_cmd_wr,
    input wire logic lnk_cmd_rd,
    input wire logic [7:0] lnk_cmd,
    input wire logic [31:0] lnk_wr_data,
    output logic [31:0] lnk_rd_data,
    output logic lnk_busy,
    output logic lnk_done,
    input wire logic enable_pin,
    input wire logic vdd_above_min,
    input wire logic all_pg,
    input wire logic [2:0] chan_en,
    input wire lsd_pkg::lsd_smp_s smp,
    input wire logic soft_rst,
    input wire logic [31:0] flash_rd_data,
    output logic flash_wr,
    output logic [31:0] flash_wr_data,
    output logic sync_o,
    output logic sync_oe
);

    lsd_pkg::lsd_lnk_s l, ln;
    lsd_pkg::lsd_core_s s, n;
    logic osc_tick;
    logic sec_tick;
    logic req_go;
    logic en_fall;
    logic save;
    logic [7:0] sel;
    logic [2:0] avg_clr;
    logic signed [16:0] diff;

    // ------------------------------------------------------------
    // link side: holds the request until the core answers
    // ------------------------------------------------------------
    always_comb begin
        ln = l;
        ln.done = 1'b0;
        ln.ack_s = {l.ack_s[1:0], s.ack_tgl};
        unique case (l.st)
            lsd_pkg::LNK_IDLE: begin
                if (lnk_cmd_wr || lnk_cmd_rd) begin
                    ln.wr = lnk_cmd_wr;
                    ln.cmd = lnk_cmd;
                    ln.data = lnk_wr_data;
                    ln.req_tgl = ~l.req_tgl;
                    ln.busy = 1'b1;
                    ln.st = lsd_pkg::LNK_WAIT;
                end
            end
            lsd_pkg::LNK_WAIT: begin
                if (l.ack_s[1] == l.ack_s[2] && l.ack_s[2] != l.ack_seen)
                begin
                    // core answer word is stable once its toggle lands
                    ln.ack_seen = l.ack_s[2];
                    ln.rd = s.rd;
                    ln.done = 1'b1;
                    ln.busy = 1'b0;
                    ln.st = lsd_pkg::LNK_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            l <= '0;
        end else begin
            l <= ln;
        end
    end

    assign lnk_rd_data = l.rd;
    assign lnk_busy = l.busy;
    assign lnk_done = l.done;

    // ------------------------------------------------------------
    // core side
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.flash_wr = 1'b0;
        save = 1'b0;
        osc_tick = 1'b0;
        sec_tick = 1'b0;
        avg_clr = 3'h0;
        diff = '0;

        // pins: change taken once stages two and three agree
        n.en_s = {s.en_s[1:0], enable_pin};
        n.vdd_s = {s.vdd_s[1:0], vdd_above_min};
        n.pg_s = {s.pg_s[1:0], all_pg};
        n.req_s = {s.req_s[1:0], l.req_tgl};
        if (s.en_s[1] == s.en_s[2]) begin
            n.en_f = s.en_s[2];
        end
        if (s.vdd_s[1] == s.vdd_s[2]) begin
            n.vdd_f = s.vdd_s[2];
        end
        if (s.pg_s[1] == s.pg_s[2]) begin
            n.pg_f = s.pg_s[2];
        end
        for (int i = 0; i < 3; i++) begin
            n.ch_s[i] = {s.ch_s[i][1:0], chan_en[i]};
            if (s.ch_s[i][1] == s.ch_s[i][2]) begin
                n.ch_f[i] = s.ch_s[i][2];
            end
        end
        en_fall = s.en_f && s.en_s[1] == s.en_s[2] && !s.en_s[2];

        // 4 MHz oscillator emulated as a fractional tick
        if (s.osc_acc + lsd_pkg::OSC_INC >= lsd_pkg::OSC_MOD) begin
            osc_tick = 1'b1;
            n.osc_acc = s.osc_acc + lsd_pkg::OSC_INC - lsd_pkg::OSC_MOD;
        end else begin
            n.osc_acc = s.osc_acc + lsd_pkg::OSC_INC;
        end

        // one-second tick from the oscillator
        if (osc_tick) begin
            if (s.sec_cnt == lsd_pkg::lsd_sec_t'(SEC_TICKS - 1)) begin
                n.sec_cnt = '0;
                sec_tick = 1'b1;
            end else begin
                n.sec_cnt = s.sec_cnt + lsd_pkg::lsd_sec_t'(1);
            end
        end

        if (s.st == lsd_pkg::CORE_RUN && sec_tick) begin
            n.life = s.life + 32'h0000_0001;
            if (s.hour_cnt == lsd_pkg::lsd_hour_t'(HOUR_SECS - 1)) begin
                n.hour_cnt = '0;
                save = 1'b1;
            end else begin
                n.hour_cnt = s.hour_cnt + lsd_pkg::lsd_hour_t'(1);
            end
        end
        // below the supply floor the save is simply not attempted
        if (en_fall && s.vdd_f) begin
            save = 1'b1;
        end

        // clear sequence window
        if (s.clr != lsd_pkg::CLR_IDLE) begin
            if (s.clr_cnt >= lsd_pkg::lsd_clr_t'(CLR_WINDOW - 1)) begin
                n.clr = lsd_pkg::CLR_IDLE;
            end else begin
                n.clr_cnt = s.clr_cnt + lsd_pkg::lsd_clr_t'(1);
            end
        end

        // peak and averages
        if (smp.valid) begin
            if (smp.val[0] > s.peak) begin
                n.peak = smp.val[0];
            end
            for (int i = 0; i < 3; i++) begin
                if (!s.avg_vld[i]) begin
                    n.avg[i] = smp.val[i];
                    n.avg_vld[i] = 1'b1;
                end else begin
                    diff = $signed({1'b0, smp.val[i]}) -
                        $signed({1'b0, s.avg[i]});
                    n.avg[i] = 16'($signed({1'b0, s.avg[i]}) +
                        (diff >>> lsd_pkg::AVG_SHIFT));
                end
            end
        end

        // host request
        req_go = s.st == lsd_pkg::CORE_RUN && s.req_s[1] == s.req_s[2] &&
            s.req_s[2] != s.req_seen;
        if (req_go) begin
            n.req_seen = s.req_s[2];
            n.ack_tgl = ~s.ack_tgl;
            if (l.wr) begin
                if (l.cmd == lsd_pkg::CMD_LIFETIME) begin
                    n.clr = lsd_pkg::CLR_IDLE;
                    n.clr_cnt = '0;
                    unique case (s.clr)
                        lsd_pkg::CLR_IDLE, lsd_pkg::CLR_GOT0: begin
                            if (l.data == lsd_pkg::WORD_ZERO) begin
                                n.clr = lsd_pkg::CLR_GOT0;
                            end else if (s.clr == lsd_pkg::CLR_GOT0 &&
                                l.data == lsd_pkg::WORD_ONES) begin
                                n.clr = lsd_pkg::CLR_GOT1;
                                n.clr_cnt = s.clr_cnt + lsd_pkg::lsd_clr_t'(1);
                            end
                        end
                        lsd_pkg::CLR_GOT1: begin
                            if (l.data == lsd_pkg::WORD_ZERO) begin
                                n.life = lsd_pkg::WORD_ZERO;
                                n.hour_cnt = '0;
                            end
                        end
                    endcase
                end else if (l.cmd == lsd_pkg::CMD_PEAK_PWR) begin
                    if (l.data[15:0] == lsd_pkg::STAT_ZERO) begin
                        n.peak = lsd_pkg::STAT_ZERO;
                    end
                end else if (lsd_pkg::is_avg(l.cmd)) begin
                    // nonzero writes are dropped
                    if (l.data[15:0] == lsd_pkg::STAT_ZERO) begin
                        avg_clr[lsd_pkg::avg_index(l.cmd)] = 1'b1;
                    end
                end else if (l.cmd == lsd_pkg::CMD_FREQ_CFG) begin
                    n.cfg = l.data[15:0];
                end
            end else begin
                unique case (l.cmd)
                    lsd_pkg::CMD_LIFETIME: n.rd = s.life;
                    lsd_pkg::CMD_PEAK_PWR: n.rd = {16'h0000, s.peak};
                    lsd_pkg::CMD_AVG_PWR, lsd_pkg::CMD_AVG_CUR,
                    lsd_pkg::CMD_AVG_TMP: begin
                        // two bytes, zero above
                        n.rd = {16'h0000,
                            s.avg[lsd_pkg::avg_index(l.cmd)]};
                    end
                    lsd_pkg::CMD_FREQ_CFG: n.rd = {16'h0000, s.cfg};
                    default: n.rd = lsd_pkg::WORD_ZERO;
                endcase
            end
        end

        for (int i = 0; i < 3; i++) begin
            if (avg_clr[i]) begin
                n.avg[i] = lsd_pkg::STAT_ZERO;
                n.avg_vld[i] = 1'b0;
            end
            if (!n.en_f || !n.ch_f[i]) begin
                n.avg[i] = lsd_pkg::STAT_ZERO;
                n.avg_vld[i] = 1'b0;
            end
        end
        if (!n.en_f || !n.ch_f[0]) begin
            n.peak = lsd_pkg::STAT_ZERO;
        end

        if (save) begin
            n.flash_wr = 1'b1;
            n.flash_data = n.life;
        end

        // frequency output divider
        sel = s.pg_f ? s.cfg[15:8] : s.cfg[7:0];
        if (sel == lsd_pkg::DIV_HIZ) begin
            n.cur_div = lsd_pkg::DIV_HIZ;
            n.div_cnt = 8'h00;
        end else if (s.cur_div == lsd_pkg::DIV_HIZ) begin
            n.cur_div = sel;
            n.div_cnt = 8'h00;
        end else if (osc_tick) begin
            if (s.div_cnt == s.cur_div - 8'h01) begin
                n.div_cnt = 8'h00;
                n.cur_div = sel;
            end else begin
                n.div_cnt = s.div_cnt + 8'h01;
            end
        end
        n.sync_oe = n.cur_div != lsd_pkg::DIV_HIZ;
        n.sync_o = n.sync_oe && n.div_cnt < {1'b0, n.cur_div[7:1]};

        // reload after reset pin, power-up or soft reset
        if (s.st == lsd_pkg::CORE_LOAD) begin
            n.life = flash_rd_data;
            n.clr = lsd_pkg::CLR_IDLE;
            n.hour_cnt = '0;
            n.st = lsd_pkg::CORE_RUN;
        end
        if (soft_rst) begin
            n.st = lsd_pkg::CORE_LOAD;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '{st: lsd_pkg::CORE_LOAD, clr: lsd_pkg::CLR_IDLE,
                cfg: lsd_pkg::CFG_RST, default: '0};
        end else begin
            s <= n;
        end
    end

    assign flash_wr = s.flash_wr;
    assign flash_wr_data = s.flash_data;
    assign sync_o = s.sync_o;
    assign sync_oe = s.sync_oe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_clr_final;
        s.clr == lsd_pkg::CLR_GOT1 && req_go && l.wr &&
            l.cmd == lsd_pkg::CMD_LIFETIME &&
            l.data == lsd_pkg::WORD_ZERO;
    endsequence

    sequence s_div_edge;
        osc_tick && s.cur_div != lsd_pkg::DIV_HIZ &&
            s.div_cnt == s.cur_div - 8'h01;
    endsequence

    chk_life_wrap: assert property (
        @(posedge core_clk) disable iff (rst)
        sec_tick && s.st == lsd_pkg::CORE_RUN && !req_go && !soft_rst &&
            s.life == lsd_pkg::WORD_ONES |=> s.life == lsd_pkg::WORD_ZERO)
        else $error("lifetime count did not wrap");

    chk_hour_save: assert property (
        @(posedge core_clk) disable iff (rst)
        sec_tick && s.st == lsd_pkg::CORE_RUN &&
            s.hour_cnt == lsd_pkg::lsd_hour_t'(HOUR_SECS - 1)
            |=> flash_wr && flash_wr_data == $past(n.life))
        else $error("hourly save missing");

    chk_enable_save: assert property (
        @(posedge core_clk) disable iff (rst)
        en_fall && !(sec_tick && s.st == lsd_pkg::CORE_RUN &&
            s.hour_cnt == lsd_pkg::lsd_hour_t'(HOUR_SECS - 1))
            |=> flash_wr == $past(s.vdd_f))
        else $error("enable fall save wrong");

    chk_reload_flash: assert property (
        @(posedge core_clk) disable iff (rst)
        s.st == lsd_pkg::CORE_LOAD && !soft_rst
            |=> s.life == $past(flash_rd_data) && s.st == lsd_pkg::CORE_RUN)
        else $error("lifetime not reloaded");

    chk_clear_seq: assert property (
        @(posedge core_clk) disable iff (rst)
        s_clr_final and !soft_rst |=> s.life == lsd_pkg::WORD_ZERO)
        else $error("clear sequence failed");

    chk_peak_track: assert property (
        @(posedge core_clk) disable iff (rst)
        smp.valid && smp.val[0] > s.peak && n.en_f && n.ch_f[0] &&
            !req_go |=> s.peak == $past(smp.val[0]))
        else $error("peak not updated");

    chk_peak_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        req_go && l.wr && l.cmd == lsd_pkg::CMD_PEAK_PWR &&
            l.data[15:0] == lsd_pkg::STAT_ZERO |=> s.peak == 16'h0000)
        else $error("peak not cleared");

    chk_avg_restart: assert property (
        @(posedge core_clk) disable iff (rst)
        avg_clr[0] |=> s.avg[0] == lsd_pkg::STAT_ZERO && !s.avg_vld[0])
        else $error("average not restarted");

    chk_force_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        !n.en_f |=> s.peak == lsd_pkg::STAT_ZERO && s.avg == '0)
        else $error("stats not forced to zero");

    chk_sync_hiz: assert property (
        @(posedge core_clk) disable iff (rst)
        sel == lsd_pkg::DIV_HIZ |=> !sync_oe && !sync_o)
        else $error("output not released");

    chk_pg_select: assert property (
        @(posedge core_clk) disable iff (rst)
        s_div_edge ##0 s.pg_f && s.cfg[15:8] != lsd_pkg::DIV_HIZ
            |=> s.cur_div == $past(s.cfg[15:8]))
        else $error("wrong divisor byte");

    chk_div_boundary: assert property (
        @(posedge core_clk) disable iff (rst)
        s.cur_div != lsd_pkg::DIV_HIZ && n.cur_div != s.cur_div &&
            n.cur_div != lsd_pkg::DIV_HIZ |-> s_div_edge)
        else $error("divisor changed mid period");

endmodule : lsd_top

// ==== rtl/lsd_pkg.sv ====
package lsd_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_LIFETIME = 8'hDD;
    localparam logic [7:0] CMD_PEAK_PWR = 8'hE0;
    localparam logic [7:0] CMD_AVG_PWR = 8'hE1;
    localparam logic [7:0] CMD_AVG_CUR = 8'hE2;
    localparam logic [7:0] CMD_AVG_TMP = 8'hE3;
    localparam logic [7:0] CMD_FREQ_CFG = 8'hEF;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CORE_CLK_HZ = 10_000_000;
    localparam int unsigned OSC_HZ = 4_000_000;
    localparam int unsigned CLR_WINDOW_MS = 8;
    localparam int unsigned CLR_WINDOW_CYC = CLR_WINDOW_MS *
        (CORE_CLK_HZ / 1000);
    localparam int unsigned SEC_TICKS_DFLT = OSC_HZ;
    localparam int unsigned HOUR_SECS_DFLT = 3600;

    typedef logic [3:0] lsd_acc_t;
    typedef logic [21:0] lsd_sec_t;
    typedef logic [11:0] lsd_hour_t;
    typedef logic [16:0] lsd_clr_t;

    // fractional step: osc_hz/core_hz = inc/mod
    localparam lsd_acc_t OSC_INC = lsd_acc_t'(OSC_HZ / 1_000_000);
    localparam lsd_acc_t OSC_MOD = lsd_acc_t'(CORE_CLK_HZ / 1_000_000);

    // ------------------------------------------------------------
    // values and reset states
    // ------------------------------------------------------------
    localparam logic [7:0] DIV_MIN = 8'h08;
    localparam logic [7:0] DIV_MAX = 8'hC8;
    localparam logic [7:0] DIV_HIZ = 8'h00;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [15:0] STAT_ZERO = 16'h0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] WORD_ONES = 32'hFFFF_FFFF;
    localparam int unsigned AVG_SHIFT = 3;

    typedef enum logic {CORE_LOAD, CORE_RUN} lsd_core_e;
    typedef enum logic [1:0] {CLR_IDLE, CLR_GOT0, CLR_GOT1} lsd_clr_e;
    typedef enum logic {LNK_IDLE, LNK_WAIT} lsd_lnk_e;

    // index 0 power, 1 current, 2 temperature
    typedef struct packed {
        logic valid;
        logic [2:0][15:0] val;
    } lsd_smp_s;

    typedef struct packed {
        lsd_lnk_e st;
        logic req_tgl;
        logic wr;
        logic [7:0] cmd;
        logic [31:0] data;
        logic [2:0] ack_s;
        logic ack_seen;
        logic [31:0] rd;
        logic busy;
        logic done;
    } lsd_lnk_s;

    typedef struct packed {
        lsd_core_e st;
        lsd_clr_e clr;
        logic [2:0] req_s;
        logic req_seen;
        logic ack_tgl;
        logic [31:0] rd;
        logic [2:0] en_s;
        logic en_f;
        logic [2:0] vdd_s;
        logic vdd_f;
        logic [2:0] pg_s;
        logic pg_f;
        logic [2:0][2:0] ch_s;
        logic [2:0] ch_f;
        lsd_acc_t osc_acc;
        lsd_sec_t sec_cnt;
        lsd_hour_t hour_cnt;
        logic [31:0] life;
        lsd_clr_t clr_cnt;
        logic [15:0] peak;
        logic [2:0][15:0] avg;
        logic [2:0] avg_vld;
        logic [15:0] cfg;
        logic [7:0] div_cnt;
        logic [7:0] cur_div;
        logic sync_o;
        logic sync_oe;
        logic flash_wr;
        logic [31:0] flash_data;
    } lsd_core_s;

    function automatic logic is_avg(input logic [7:0] cmd);
        return cmd == CMD_AVG_PWR || cmd == CMD_AVG_CUR ||
            cmd == CMD_AVG_TMP;
    endfunction : is_avg

    function automatic logic [1:0] avg_index(input logic [7:0] cmd);
        return 2'(cmd - CMD_AVG_PWR);
    endfunction : avg_index

endpackage : lsd_pkg

// ==== verification/lsd_host.sv ====
`timescale 1ns/10ps
module lsd_host (
    input wire logic link_clk,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [7:0] cmd,
    output logic [31:0] wr_data,
    input wire logic [31:0] rd_data,
    input wire logic done
);
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd = 8'h00;
        wr_data = 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // one request outstanding; strobe lives one link cycle
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] c,
            input logic [31:0] d, output logic [31:0] q,
            output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        q = 32'h0000_0000;
        @(negedge link_clk);
        cmd_wr = wr;
        cmd_rd = ~wr;
        cmd = c;
        wr_data = d;
        @(negedge link_clk);
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        // command and data stay put until the answer arrives
        while (!ok && n < 40) begin
            @(negedge link_clk);
            n++;
            if (done === 1'b1) begin
                ok = 1'b1;
                q = rd_data;
            end
        end
    endtask : xfer
endmodule : lsd_host

// ==== verification/lifetime_stats_and_sync_divider_tb.sv ====
`timescale 1ns/10ps
module lifetime_stats_and_sync_divider_tb;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic enable_pin = 1'b1;
    logic vdd_above_min = 1'b1;
    logic all_pg = 1'b1;
    logic [2:0] chan_en = 3'h7;
    lsd_pkg::lsd_smp_s smp = '0;
    logic soft_rst = 1'b0;
    logic [31:0] flash_rd_data = 32'h0000_0005;
    logic cmd_wr, cmd_rd, busy, done, flash_wr, sync_o, sync_oe;
    logic [7:0] cmd;
    logic [31:0] wr_data, rd_data, flash_wr_data;
    int mismatches = 0;
    int samples_checked = 0;

    lsd_top #(.SEC_TICKS(10), .HOUR_SECS(3), .CLR_WINDOW(200)) u_dut (
        .core_clk(core_clk), .rst(rst), .link_clk(link_clk),
        .lnk_cmd_wr(cmd_wr), .lnk_cmd_rd(cmd_rd), .lnk_cmd(cmd),
        .lnk_wr_data(wr_data), .lnk_rd_data(rd_data), .lnk_busy(busy),
        .lnk_done(done), .enable_pin(enable_pin),
        .vdd_above_min(vdd_above_min), .all_pg(all_pg),
        .chan_en(chan_en), .smp(smp), .soft_rst(soft_rst),
        .flash_rd_data(flash_rd_data), .flash_wr(flash_wr),
        .flash_wr_data(flash_wr_data), .sync_o(sync_o),
        .sync_oe(sync_oe));

    lsd_host u_host (.link_clk(link_clk), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd(cmd), .wr_data(wr_data),
        .rd_data(rd_data), .done(done));

    initial begin
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] c, input logic [31:0] d);
        logic [31:0] q;
        logic ok;
        u_host.xfer(1'b1, c, d, q, ok);
        chk({30'h0, ok, busy}, 32'h2);
    endtask : wr

    task automatic rd(input logic [7:0] c, output logic [31:0] q);
        logic ok;
        u_host.xfer(1'b0, c, 32'h0, q, ok);
        chk({31'h0, ok}, 32'h1);
    endtask : rd

    task automatic rdc(input logic [7:0] c, input logic [31:0] e);
        logic [31:0] q;
        rd(c, q);
        chk(q, e);
    endtask : rdc

    task automatic wait_fw(output int n);
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (flash_wr !== 1'b1 && n < 300);
    endtask : wait_fw

    task automatic send(input logic [15:0] v);
        // callers may return on a link edge; realign to the core clock
        cyc(1);
        smp.valid = 1'b1;
        for (int i = 0; i < 3; i++) smp.val[i] = v + 16'(i);
        cyc(1);
        smp.valid = 1'b0;
        cyc(1);
    endtask : send

    // four periods cover the whole fractional tick pattern
    task automatic period(input int exp);
        int n;
        int e;
        int k;
        logic p;
        n = 0;
        e = 0;
        k = 0;
        p = sync_o;
        while (e < 5 && k < 6000) begin
            cyc(1);
            k++;
            if (e > 0) n++;
            if (sync_o === 1'b1 && p === 1'b0) e++;
            p = sync_o;
        end
        chk(32'(n), 32'(exp));
    endtask : period

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_hourly;
        int n;
        logic [31:0] a;
        wait_fw(n);
        a = flash_wr_data;
        wait_fw(n);
        chk(32'(n), 32'h4B);
        chk(flash_wr_data - a, 32'h3);
    endtask : t_hourly

    task automatic t_enfall(input logic v);
        int n;
        int hits;
        vdd_above_min = v;
        wait_fw(n);
        cyc(20);
        enable_pin = 1'b0;
        hits = 0;
        repeat (15) begin
            cyc(1);
            hits += int'(flash_wr === 1'b1);
        end
        chk(32'(hits), {31'h0, v});
        enable_pin = 1'b1;
        cyc(10);
    endtask : t_enfall

    task automatic soft_load(input logic [31:0] v);
        cyc(1);
        flash_rd_data = v;
        soft_rst = 1'b1;
        cyc(1);
        soft_rst = 1'b0;
    endtask : soft_load

    task automatic t_reload;
        logic [31:0] q;
        soft_load(32'hFFFF_FFFE);
        cyc(100);
        rd(lsd_pkg::CMD_LIFETIME, q);
        chk({31'h0, (q - flash_rd_data) inside {[3:6]}},
            32'h1);
    endtask : t_reload

    task automatic t_clear;
        logic [31:0] q;
        soft_load(32'h1000_0000);
        wr(lsd_pkg::CMD_LIFETIME, 32'h0);
        wr(lsd_pkg::CMD_LIFETIME, 32'hFFFF_FFFF);
        cyc(300);
        wr(lsd_pkg::CMD_LIFETIME, 32'h0);
        rd(lsd_pkg::CMD_LIFETIME, q);
        chk({31'h0, q >= 32'h1000_0000}, 32'h1);
        cyc(300);
        wr(lsd_pkg::CMD_LIFETIME, 32'h0);
        wr(lsd_pkg::CMD_LIFETIME, 32'hFFFF_FFFF);
        wr(lsd_pkg::CMD_LIFETIME, 32'h0);
        rd(lsd_pkg::CMD_LIFETIME, q);
        chk({31'h0, q < 32'h4}, 32'h1);
    endtask : t_clear

    task automatic t_stats;
        for (int i = 0; i < 4; i++) wr(8'hE0 + 8'(i), 32'h0);
        send(16'h0100);
        send(16'h0300);
        send(16'h0200);
        rdc(lsd_pkg::CMD_PEAK_PWR, 32'h0300);
        for (int i = 0; i < 3; i++) begin
            rdc(8'hE1 + 8'(i), 32'h0158 + 32'(i));
        end
        wr(lsd_pkg::CMD_AVG_PWR, 32'h0000_1234);
        rdc(lsd_pkg::CMD_AVG_PWR, 32'h0158);
        wr(lsd_pkg::CMD_PEAK_PWR, 32'h0);
        rdc(lsd_pkg::CMD_PEAK_PWR, 32'h0);
        wr(lsd_pkg::CMD_AVG_CUR, 32'h0);
        send(16'h0050);
        rdc(lsd_pkg::CMD_AVG_CUR, 32'h0051);
        rdc(lsd_pkg::CMD_PEAK_PWR, 32'h0050);
        chan_en = 3'h5;
        cyc(10);
        rdc(lsd_pkg::CMD_AVG_CUR, 32'h0);
        enable_pin = 1'b0;
        cyc(10);
        for (int i = 0; i < 4; i++) rdc(8'hE0 + 8'(i), 32'h0);
        enable_pin = 1'b1;
        chan_en = 3'h7;
        cyc(10);
    endtask : t_stats

    task automatic t_sync;
        int n;
        wr(lsd_pkg::CMD_FREQ_CFG, 32'h0000_19C8);
        cyc(300);
        period(250);
        all_pg = 1'b0;
        cyc(600);
        period(2000);
        wr(lsd_pkg::CMD_FREQ_CFG, 32'h0000_0808);
        cyc(600);
        period(80);
        all_pg = 1'b1;
        cyc(100);
        period(80);
        wr(lsd_pkg::CMD_FREQ_CFG, 32'h0000_7D00);
        all_pg = 1'b0;
        cyc(100);
        n = 0;
        repeat (200) begin
            cyc(1);
            n += int'(sync_oe !== 1'b0);
        end
        chk(32'(n), 32'h0);
        all_pg = 1'b1;
        cyc(20);
        period(1250);
        chk({31'h0, sync_oe}, 32'h1);
    endtask : t_sync

    // ------------------------------------------------------------
    // sequence and verdict
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        cyc(10);
        t_hourly();
        t_enfall(1'b1);
        t_enfall(1'b0);
        vdd_above_min = 1'b1;
        t_reload();
        t_clear();
        t_stats();
        t_sync();
        finish_test();
    end

    // whole run is near 10000 core cycles; allow five times that
    initial begin
        #5_000_000;
        mismatches++;
        finish_test();
    end
endmodule : lifetime_stats_and_sync_divider_tb
